// File: verilog/crmc_top.sv
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
module crmc_top #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic ref_a_i,
  input wire logic ref_b_i,
  output logic [15:0] cust_a_freq_lower_limit_o,
  output logic [15:0] cust_a_freq_upper_limit_o,
  output logic [7:0] cust_a_monitored_cycles_o,
  output logic cust_a_prescale_enable_o,
  output logic [13:0] cust_b_multiplier_o,
  output logic [7:0] cust_b_cycle_lower_bound_o,
  output logic [7:0] cust_b_cycle_upper_bound_o,
  output logic cust_a_window_done_o,
  output logic [15:0] cust_a_measured_o,
  output logic cust_a_fail_o,
  output logic cust_b_fail_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  ////////////////////////////////////////////////////////////////////////////////
  // register bus

  logic [crmc_pkg::NUM_CFG-1:0][7:0] cfg, next_cfg;
  logic aw_full, next_aw_full, w_full, next_w_full;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [7:0] w_data, next_w_data;
  logic w_strb0, next_w_strb0;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [7:0] rdata, next_rdata;
  logic wr_fire, wr_hit;
  logic [3:0] wr_slot;
  logic rd_hit, rd_status;
  logic [3:0] rd_slot;
  logic a_fail, b_fail;

  // address decode: index field, upper bits must be clear
  function automatic logic [4:0] crmc_decode(input logic [ADDR_W-1:0] addr);
    logic [7:0] diff;
    logic hit;
    diff = addr[9:2] - crmc_pkg::IDX_A_LOW_LO;
    hit = (addr[ADDR_W-1:10] == '0) && (diff < 8'(crmc_pkg::NUM_CFG));
    return {hit, diff[3:0]};
  endfunction : crmc_decode

  assign s_axi_awready_o = !aw_full && !bvalid;
  assign s_axi_wready_o = !w_full && !bvalid;
  assign s_axi_arready_o = !rvalid;
  assign wr_fire = aw_full && w_full;
  assign {wr_hit, wr_slot} = crmc_decode(aw_addr);
  assign {rd_hit, rd_slot} = crmc_decode(s_axi_araddr_i);
  assign rd_status = (s_axi_araddr_i[ADDR_W-1:10] == '0) && (s_axi_araddr_i[9:2] == crmc_pkg::IDX_STATUS);

  // address and data taken in either order, write once both are held
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb0 = w_strb0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_cfg = cfg;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata_i[7:0];
      next_w_strb0 = s_axi_wstrb_i[0];
    end
    if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = crmc_pkg::RESP_OKAY;
      if (wr_hit) begin
        if (w_strb0) begin
          next_cfg[wr_slot] = w_data & crmc_pkg::CFG_MASK[wr_slot];
        end
      end else if (aw_addr[ADDR_W-1:10] != '0 || aw_addr[9:2] != crmc_pkg::IDX_STATUS) begin
        next_bresp = crmc_pkg::RESP_SLVERR; // status write is ignored, others unmapped
      end
    end
  end

  // read answers one cycle after the address is taken
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_rvalid = 1'b1;
      next_rresp = crmc_pkg::RESP_OKAY;
      next_rdata = 8'h00;
      if (rd_hit) begin
        next_rdata = cfg[rd_slot];
      end else if (rd_status) begin
        next_rdata[crmc_pkg::STAT_A_FAIL_BIT] = a_fail;
        next_rdata[crmc_pkg::STAT_B_FAIL_BIT] = b_fail;
      end else begin
        next_rresp = crmc_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg <= {crmc_pkg::NUM_CFG{crmc_pkg::CFG_RESET}};
      aw_full <= 1'b0;
      aw_addr <= '0;
      w_full <= 1'b0;
      w_data <= 8'h00;
      w_strb0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 8'h00;
      rresp <= 2'h0;
    end else begin
      cfg <= next_cfg;
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb0 <= next_w_strb0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rresp_o = rresp;
  assign s_axi_rdata_o = {24'h000000, rdata};

  // limits and settings handed to the monitor
  assign cust_a_freq_lower_limit_o = {cfg[crmc_pkg::SLOT_A_LOW_HI], cfg[crmc_pkg::SLOT_A_LOW_LO]};
  assign cust_a_freq_upper_limit_o = {cfg[crmc_pkg::SLOT_A_UP_HI], cfg[crmc_pkg::SLOT_A_UP_LO]};
  assign cust_a_monitored_cycles_o = cfg[crmc_pkg::SLOT_A_CYCLES];
  assign cust_a_prescale_enable_o = cfg[crmc_pkg::SLOT_A_PRESCALE][crmc_pkg::PRESCALE_BIT];
  assign cust_b_multiplier_o = {cfg[crmc_pkg::SLOT_B_MULT_HI][crmc_pkg::MULT_HI_WIDTH-1:0],
                                cfg[crmc_pkg::SLOT_B_MULT_LO]};
  assign cust_b_cycle_lower_bound_o = cfg[crmc_pkg::SLOT_B_LOW];
  assign cust_b_cycle_upper_bound_o = cfg[crmc_pkg::SLOT_B_HIGH];

  a_upper_hi_write: assert property (wr_fire && wr_hit && w_strb0 && wr_slot == crmc_pkg::SLOT_A_UP_HI
    |=> cust_a_freq_upper_limit_o[15:8] == $past(w_data)) else $error("upper limit high byte not taken");
  a_lower_lo_write: assert property (wr_fire && wr_hit && w_strb0 && wr_slot == crmc_pkg::SLOT_A_LOW_LO
    |=> cust_a_freq_lower_limit_o[7:0] == $past(w_data)) else $error("lower limit low byte not taken");
  a_mult_hi_write: assert property (wr_fire && wr_hit && w_strb0 && wr_slot == crmc_pkg::SLOT_B_MULT_HI
    |=> cust_b_multiplier_o[13:8] == $past(w_data[5:0])) else $error("multiplier high bits not taken");

  ////////////////////////////////////////////////////////////////////////////////
  // reference inputs: two-flop synchronisers and edge detect

  logic [2:0] ref_a_sync, ref_b_sync;
  logic a_edge, b_edge;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_a_sync <= 3'h0;
      ref_b_sync <= 3'h0;
    end else begin
      ref_a_sync <= {ref_a_sync[1:0], ref_a_i};
      ref_b_sync <= {ref_b_sync[1:0], ref_b_i};
    end
  end

  assign a_edge = ref_a_sync[1] && !ref_a_sync[2];
  assign b_edge = ref_b_sync[1] && !ref_b_sync[2];

  ////////////////////////////////////////////////////////////////////////////////
  // custom A: prescaler, window and frequency check

  logic [1:0] pre_cnt, next_pre_cnt;
  logic a_tick;
  crmc_pkg::crmc_win_t win_state, next_win_state;
  logic [7:0] tick_cnt, next_tick_cnt;
  logic [15:0] clk_cnt, next_clk_cnt, measured, next_measured;
  logic win_end, done, next_done, next_a_fail;

  // every fourth edge passes when the prescaler is on
  assign a_tick = a_edge && (!cust_a_prescale_enable_o || pre_cnt == crmc_pkg::PRESCALE_LAST);
  assign win_end = (win_state == crmc_pkg::WIN_MEAS) && a_tick && tick_cnt == cust_a_monitored_cycles_o;

  always_comb begin
    next_pre_cnt = pre_cnt;
    next_win_state = win_state;
    next_tick_cnt = tick_cnt;
    next_clk_cnt = clk_cnt;
    next_measured = measured;
    next_done = 1'b0;
    next_a_fail = a_fail;
    if (!cust_a_prescale_enable_o) begin
      next_pre_cnt = 2'h0;
    end else if (a_edge) begin
      next_pre_cnt = pre_cnt + 2'h1;
    end
    unique case (win_state)
      crmc_pkg::WIN_IDLE: begin
        if (a_tick) begin
          next_win_state = crmc_pkg::WIN_MEAS;
          next_tick_cnt = 8'h00;
          next_clk_cnt = 16'h0000;
        end
      end
      crmc_pkg::WIN_MEAS: begin
        if (clk_cnt != 16'hffff) begin
          next_clk_cnt = clk_cnt + 16'h0001; // saturates on a dead reference
        end
        if (win_end) begin
          // window closes; the same edge opens the next one
          next_done = 1'b1;
          next_measured = clk_cnt;
          next_a_fail = (clk_cnt < cust_a_freq_lower_limit_o) || (clk_cnt > cust_a_freq_upper_limit_o);
          next_tick_cnt = 8'h00;
          next_clk_cnt = 16'h0000;
        end else if (a_tick) begin
          next_tick_cnt = tick_cnt + 8'h01;
        end
      end
      default: begin
        next_win_state = crmc_pkg::WIN_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_cnt <= 2'h0;
      win_state <= crmc_pkg::WIN_IDLE;
      tick_cnt <= 8'h00;
      clk_cnt <= 16'h0000;
      measured <= 16'h0000;
      done <= 1'b0;
      a_fail <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      win_state <= next_win_state;
      tick_cnt <= next_tick_cnt;
      clk_cnt <= next_clk_cnt;
      measured <= next_measured;
      done <= next_done;
      a_fail <= next_a_fail;
    end
  end

  assign cust_a_window_done_o = done;
  assign cust_a_measured_o = measured;
  assign cust_a_fail_o = a_fail;

  sequence s_win_close;
    win_state == crmc_pkg::WIN_MEAS && a_tick && tick_cnt == cust_a_monitored_cycles_o;
  endsequence
  sequence s_in_range;
    clk_cnt >= cust_a_freq_lower_limit_o && clk_cnt <= cust_a_freq_upper_limit_o;
  endsequence

  a_window_close: assert property (s_win_close |=> cust_a_window_done_o && tick_cnt == 8'h00)
    else $error("window did not close after count plus one");
  a_window_only: assert property (cust_a_window_done_o |-> $past(tick_cnt) == $past(cust_a_monitored_cycles_o))
    else $error("window closed early");
  a_prescale_div: assert property (cust_a_prescale_enable_o && a_tick |-> a_edge && pre_cnt == 2'h3)
    else $error("prescaler passed a tick early");
  a_prescale_off: assert property (!cust_a_prescale_enable_o && a_edge |-> a_tick)
    else $error("edge dropped without prescale");
  a_a_pass: assert property ((s_win_close and s_in_range) |=> !cust_a_fail_o)
    else $error("in-range window flagged failed");

  ////////////////////////////////////////////////////////////////////////////////
  // custom B: single-cycle period check

  logic [7:0] period, next_period;
  logic b_seen, next_b_seen, next_b_fail;

  always_comb begin
    next_period = period;
    next_b_seen = b_seen;
    next_b_fail = b_fail;
    if (b_edge) begin
      next_b_seen = 1'b1;
      next_period = 8'h01;
      if (b_seen) begin
        next_b_fail = (period < cust_b_cycle_lower_bound_o) || (period > cust_b_cycle_upper_bound_o);
      end
    end else if (period != 8'hff) begin
      next_period = period + 8'h01; // saturates on a dead reference
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      period <= 8'h00;
      b_seen <= 1'b0;
      b_fail <= 1'b0;
    end else begin
      period <= next_period;
      b_seen <= next_b_seen;
      b_fail <= next_b_fail;
    end
  end

  assign cust_b_fail_o = b_fail;

  a_b_short_cycle: assert property (b_edge && b_seen && period < cust_b_cycle_lower_bound_o |=> cust_b_fail_o)
    else $error("short cycle not flagged");
  a_b_long_cycle: assert property (b_edge && b_seen && period > cust_b_cycle_upper_bound_o |=> cust_b_fail_o)
    else $error("long cycle not flagged");
endmodule : crmc_top

// File: verilog/crmc_pkg.sv
package crmc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_A_LOW_LO = 8'h6b;
  localparam logic [7:0] IDX_A_LOW_HI = 8'h6c;
  localparam logic [7:0] IDX_A_UP_LO = 8'h6d;
  localparam logic [7:0] IDX_A_UP_HI = 8'h6e;
  localparam logic [7:0] IDX_A_CYCLES = 8'h6f;
  localparam logic [7:0] IDX_A_PRESCALE = 8'h70;
  localparam logic [7:0] IDX_B_MULT_LO = 8'h71;
  localparam logic [7:0] IDX_B_MULT_HI = 8'h72;
  localparam logic [7:0] IDX_B_LOW = 8'h73;
  localparam logic [7:0] IDX_B_HIGH = 8'h74;
  localparam logic [7:0] IDX_STATUS = 8'h7b;
  localparam int NUM_CFG = 10;
  // slots of the configuration array, counted from the first index
  localparam logic [3:0] SLOT_A_LOW_LO = 4'h0;
  localparam logic [3:0] SLOT_A_LOW_HI = 4'h1;
  localparam logic [3:0] SLOT_A_UP_LO = 4'h2;
  localparam logic [3:0] SLOT_A_UP_HI = 4'h3;
  localparam logic [3:0] SLOT_A_CYCLES = 4'h4;
  localparam logic [3:0] SLOT_A_PRESCALE = 4'h5;
  localparam logic [3:0] SLOT_B_MULT_LO = 4'h6;
  localparam logic [3:0] SLOT_B_MULT_HI = 4'h7;
  localparam logic [3:0] SLOT_B_LOW = 4'h8;
  localparam logic [3:0] SLOT_B_HIGH = 4'h9;
  // writable bits per slot; reserved bits read as zero
  localparam logic [NUM_CFG-1:0][7:0] CFG_MASK = {8'hff, 8'hff, 8'h3f, 8'hff, 8'h01,
                                                  8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] CFG_RESET = 8'h00;
  // field positions
  localparam int PRESCALE_BIT = 0;
  localparam int MULT_HI_WIDTH = 6;
  localparam int STAT_A_FAIL_BIT = 0;
  localparam int STAT_B_FAIL_BIT = 1;
  // prescale ratio and axi responses
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // custom A window state
  typedef enum logic [1:0] {
    WIN_IDLE = 2'b01,
    WIN_MEAS = 2'b10
  } crmc_win_t;
endpackage : crmc_pkg

// File: verif/crmc_tb.sv
`timescale 1ns/1ns
module testbench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic ref_a = 1'b0, ref_b = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, a_done, a_fail, b_fail, a_pre;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [15:0] a_low, a_up, a_meas;
  logic [7:0] a_cyc, b_low, b_high;
  logic [13:0] b_mult;
  logic [16:0] b_tab [4] = '{{8'd10, 8'd14, 1'b0}, {8'd10, 8'd11, 1'b1}, {8'd13, 8'd20, 1'b1}, {8'd12, 8'd12, 1'b0}};
  int n_mismatch = 0, checks = 0, per_a = 0, per_b = 0;

  crmc_top dut (
    .ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .ref_a_i(ref_a), .ref_b_i(ref_b),
    .cust_a_freq_lower_limit_o(a_low), .cust_a_freq_upper_limit_o(a_up),
    .cust_a_monitored_cycles_o(a_cyc), .cust_a_prescale_enable_o(a_pre),
    .cust_b_multiplier_o(b_mult), .cust_b_cycle_lower_bound_o(b_low),
    .cust_b_cycle_upper_bound_o(b_high), .cust_a_window_done_o(a_done),
    .cust_a_measured_o(a_meas), .cust_a_fail_o(a_fail), .cust_b_fail_o(b_fail)
  );

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // reference pin generators; a period of zero parks the pin low
  always begin
    @(posedge ref_clk);
    if (per_a > 0) begin
      ref_a <= 1'b1;
      repeat (per_a / 2) @(posedge ref_clk);
      ref_a <= 1'b0;
      repeat (per_a - per_a / 2 - 1) @(posedge ref_clk);
    end
  end

  always begin
    @(posedge ref_clk);
    if (per_b > 0) begin
      ref_b <= 1'b1;
      repeat (per_b / 2) @(posedge ref_clk);
      ref_b <= 1'b0;
      repeat (per_b - per_b / 2 - 1) @(posedge ref_clk);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // byte address of a register index
  function automatic logic [11:0] addr_of(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : addr_of

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // bus write; handshakes sampled at the falling edge before the taking edge
  task automatic wr(input logic [11:0] addr, input logic [7:0] val, input logic [3:0] strb);
    logic aw_hs, w_hs, aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge ref_clk);
    awaddr <= addr;
    wdata <= {24'h0, val};
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no cycle limit here: only the watchdog ends a wait
    while (!(aw_done && w_done)) begin
      @(negedge ref_clk);
      aw_hs = awvalid && (awready === 1'b1);
      w_hs = wvalid && (wready === 1'b1);
      @(posedge ref_clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      aw_done = aw_done | aw_hs;
      w_done = w_done | w_hs;
    end
    do begin
      @(negedge ref_clk);
    end while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge ref_clk);
    bready <= 1'b0;
  endtask : wr

  // bus read; data and response land in rd and resp
  task automatic rd_reg(input logic [11:0] addr);
    @(posedge ref_clk);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge ref_clk);
    end while (arready !== 1'b1);
    @(posedge ref_clk);
    arvalid <= 1'b0;
    do begin
      @(negedge ref_clk);
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    @(posedge ref_clk);
    rready <= 1'b0;
  endtask : rd_reg

  // wait for a number of custom A window ends
  task automatic wait_window(input int cnt);
    repeat (cnt) begin
      do begin
        @(negedge ref_clk);
      end while (a_done !== 1'b1);
    end
  endtask : wait_window

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    complete_run();
  end

  // test sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (logic [7:0] k = 8'h6b; k <= 8'h74; k++) begin
      rd_reg(addr_of(k));
      check(rd, 32'h0);
      wr(addr_of(k), 8'hff, 4'h1);
      rd_reg(addr_of(k));
      check(rd, (k == crmc_pkg::IDX_A_PRESCALE) ? 32'h01 : (k == crmc_pkg::IDX_B_MULT_HI) ? 32'h3f : 32'hff);
    end
    $display("test reset values and access done");
    for (logic [7:0] k = 8'h6b; k <= 8'h74; k++) wr(addr_of(k), k - 8'h5b, 4'h1);
    @(negedge ref_clk);
    check(a_low, 16'h1110);
    check(a_up, 16'h1312);
    check(a_cyc, 8'h14);
    check(a_pre, 1'b1);
    check(b_mult, 14'h1716);
    check(b_low, 8'h18);
    check(b_high, 8'h19);
    wr(addr_of(8'h73), 8'h55, 4'h0);
    check(resp, crmc_pkg::RESP_OKAY);
    rd_reg(addr_of(8'h73));
    check(rd, 32'h18);
    wr(addr_of(crmc_pkg::IDX_STATUS), 8'hff, 4'h1);
    check(resp, crmc_pkg::RESP_OKAY);
    rd_reg(addr_of(crmc_pkg::IDX_STATUS));
    check(rd, 32'h0);
    wr(12'h040, 8'h5a, 4'h1);
    check(resp, crmc_pkg::RESP_SLVERR);
    rd_reg(12'h040);
    check(rd, 32'h0);
    check(resp, crmc_pkg::RESP_SLVERR);
    rd_reg(12'hdb0);
    check(resp, crmc_pkg::RESP_SLVERR);
    $display("test field layout and decode done");
    wr(addr_of(8'h6b), 8'd30, 4'h1);
    wr(addr_of(8'h6c), 8'd0, 4'h1);
    wr(addr_of(8'h6d), 8'd50, 4'h1);
    wr(addr_of(8'h6e), 8'd0, 4'h1);
    wr(addr_of(8'h6f), 8'd3, 4'h1);
    wr(addr_of(8'h70), 8'd0, 4'h1);
    per_a = 10;
    wait_window(3);
    check(a_meas, 16'd39);
    check(a_fail, 1'b0);
    wr(addr_of(8'h6d), 8'd32, 4'h1);
    wait_window(3);
    check(a_fail, 1'b1);
    wr(addr_of(8'h6f), 8'd1, 4'h1);
    wr(addr_of(8'h6d), 8'd64, 4'h1);
    wr(addr_of(8'h70), 8'd1, 4'h1);
    per_a = 6;
    wait_window(3);
    check(a_meas, 16'd47);
    check(a_fail, 1'b0);
    $display("test custom A window done");
    per_b = 12;
    for (int j = 0; j < 4; j++) begin
      wr(addr_of(8'h73), b_tab[j][16:9], 4'h1);
      wr(addr_of(8'h74), b_tab[j][8:1], 4'h1);
      repeat (60) @(posedge ref_clk);
      @(negedge ref_clk);
      check(b_fail, b_tab[j][0]);
    end
    wr(addr_of(8'h74), 8'd11, 4'h1);
    repeat (60) @(posedge ref_clk);
    rd_reg(addr_of(crmc_pkg::IDX_STATUS));
    check(rd, 32'h2);
    $display("test custom B bounds done");
    complete_run();
  end
endmodule : testbench
